// File: core/lvrc_pkg.sv
// Constants, field layouts and types shared by the low-voltage reset control block.
package lvrc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SRS = 8'h01;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h02;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h03;
    localparam logic [7:0] ADDR_MODE = 8'h04;

    localparam int CTRL_SUP_EN_BIT = 0;
    localparam int CTRL_STOP_EN_BIT = 1;
    localparam int CTRL_LVR_EN_BIT = 2;
    localparam int CTRL_THR_SEL_BIT = 3;
    localparam int CTRL_WARN_IE_BIT = 4;
    localparam int CTRL_WARN_FLAG_BIT = 5;
    localparam int CTRL_WARN_ACK_BIT = 6;
    localparam int CTRL_FIELD_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h05;

    localparam int SRS_POR_BIT = 7;
    localparam int SRS_LVD_BIT = 1;
    localparam logic [7:0] SRS_AFTER_POR = 8'h82;
    localparam logic [7:0] SRS_AFTER_LVD = 8'h02;

    localparam int IRQ_W = 3;
    localparam int IRQ_WARN_BIT = 0;
    localparam int IRQ_DETECT_BIT = 1;
    localparam int IRQ_RECOVER_BIT = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    localparam int CMP_N = 3;
    localparam int CLK_MHZ = 40;
    localparam int FILTER_NS = 100;
    localparam int FILTER_CYCLES = (FILTER_NS * CLK_MHZ + 999) / 1000;

    typedef struct packed {
        logic warn_ie;
        logic thr_sel;
        logic lvr_en;
        logic stop_en;
        logic sup_en;
    } lvrc_ctrl_type;

    typedef struct packed {
        logic warn_below;
        logic high_below;
        logic low_below;
    } lvrc_cmp_type;

    typedef enum logic [2:0] {
        ST_POR_HOLD = 3'b001,
        ST_RUN = 3'b010,
        ST_LVD_HOLD = 3'b100
    } lvrc_state_type;

    typedef enum logic [2:0] {
        MODE_RUN = 3'b001,
        MODE_RETAIN = 3'b010,
        MODE_DEEP = 3'b100
    } lvrc_mode_type;

endpackage

// File: core/lvrc_qualify.sv
// Comparator qualifier: passes a level only after it has been stable for a set number of cycles.
module lvrc_qualify #(
    parameter int STABLE_CYCLES = lvrc_pkg::FILTER_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic level_i,
    output logic level_o
);

    localparam int CNT_W = $clog2(STABLE_CYCLES + 1);

    logic [CNT_W-1:0] count_r;
    logic level_r;

    if (STABLE_CYCLES < 1)
    begin : g_bad_stable
        $error("lvrc_qualify: STABLE_CYCLES must be at least one");
    end

    // Output starts at "below" so a supply that is still rising keeps reset held.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count_r <= '0;
            level_r <= 1'b1;
        end
        else if (level_i == level_r)
        begin
            count_r <= '0;
        end
        else if (count_r == CNT_W'(STABLE_CYCLES - 1))
        begin
            count_r <= '0;
            level_r <= level_i;
        end
        else
        begin
            count_r <= count_r + 1'b1;
        end
    end

    assign level_o = level_r;

endmodule // lvrc_qualify

// File: core/lvrc_top.sv
// Low-voltage reset control: power-on hold, low-voltage reset, warning flag and stop interplay.
module lvrc_top #(
    parameter int STABLE_CYCLES = lvrc_pkg::FILTER_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire lvrc_pkg::lvrc_cmp_type cmp_i,
    input wire logic stop_req_i,
    input wire logic stop_deep_i,
    input wire logic wake_i,
    input wire logic [lvrc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [lvrc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [lvrc_pkg::DATA_W-1:0] rdata_o,
    output logic system_reset_o,
    output lvrc_pkg::lvrc_mode_type stop_mode_o,
    output logic supervisor_active_o,
    output logic warning_irq_o,
    output logic irq_o
);

    logic rst_meta_r;
    logic rst_sync_n_r;
    logic rst_n;

    lvrc_pkg::lvrc_cmp_type cmp_q;
    lvrc_pkg::lvrc_ctrl_type ctrl_r;
    lvrc_pkg::lvrc_state_type state_r;
    lvrc_pkg::lvrc_state_type state_nxt;
    lvrc_pkg::lvrc_mode_type mode_r;

    logic [lvrc_pkg::DATA_W-1:0] srs_r;
    logic [lvrc_pkg::DATA_W-1:0] rdata_r;
    logic [lvrc_pkg::IRQ_W-1:0] irq_stat_r;
    logic [lvrc_pkg::IRQ_W-1:0] irq_mask_r;
    logic [lvrc_pkg::IRQ_W-1:0] irq_set;
    logic [lvrc_pkg::IRQ_W-1:0] irq_clr;
    logic system_reset_r;
    logic warn_flag_r;
    logic detect_prev_r;

    logic active;
    logic sel_below;
    logic detect;
    logic warn_set;
    logic warn_ack;
    logic wr_ctrl;
    logic enter_lvd;
    logic leave_lvd;
    logic [lvrc_pkg::DATA_W-1:0] ctrl_view;

    // Release of the external reset is synchronised; assertion stays asynchronous.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    assign rst_n = rst_sync_n_r;

    // A zero count would pass comparator chatter straight into the reset logic.
    if (STABLE_CYCLES < 1)
    begin : g_bad_stable
        $error("lvrc_top: STABLE_CYCLES must be at least one");
    end

    // Comparator outputs can chatter near a threshold, so each is qualified before use.
    generate
        for (genvar g = 0; g < lvrc_pkg::CMP_N; g++)
        begin : g_qual
            lvrc_qualify #(
                .STABLE_CYCLES(STABLE_CYCLES)
            ) u_qual (
                .clk_i(clk_i),
                .rst_n_i(rst_n),
                .level_i(cmp_i[g]),
                .level_o(cmp_q[g])
            );
        end
    endgenerate

    always_comb
    begin
        active = ctrl_r.sup_en && ((mode_r == lvrc_pkg::MODE_RUN) || ctrl_r.stop_en);
        sel_below = ctrl_r.thr_sel ? cmp_q.high_below : cmp_q.low_below;
        detect = active && sel_below;
        warn_set = active && ctrl_r.warn_ie && cmp_q.warn_below;
        wr_ctrl = wr_i && (addr_i == lvrc_pkg::ADDR_CTRL);
        warn_ack = wr_ctrl && wdata_i[lvrc_pkg::CTRL_WARN_ACK_BIT];
    end

    // Acknowledge is write-only, so it always reads back as zero.
    always_comb
    begin
        ctrl_view = '0;
        ctrl_view[lvrc_pkg::CTRL_FIELD_W-1:0] = ctrl_r;
        ctrl_view[lvrc_pkg::CTRL_WARN_FLAG_BIT] = warn_flag_r;
    end

    // The power-on hold always watches the low threshold; the select bit applies after it.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            lvrc_pkg::ST_POR_HOLD:
            begin
                if (!cmp_q.low_below)
                begin
                    state_nxt = lvrc_pkg::ST_RUN;
                end
            end
            lvrc_pkg::ST_RUN:
            begin
                if (detect && ctrl_r.lvr_en)
                begin
                    state_nxt = lvrc_pkg::ST_LVD_HOLD;
                end
            end
            lvrc_pkg::ST_LVD_HOLD:
            begin
                if (!sel_below)
                begin
                    state_nxt = lvrc_pkg::ST_RUN;
                end
            end
            default:
            begin
                state_nxt = lvrc_pkg::ST_POR_HOLD;
            end
        endcase
    end

    assign enter_lvd = (state_r == lvrc_pkg::ST_RUN) && (state_nxt == lvrc_pkg::ST_LVD_HOLD);
    assign leave_lvd = (state_r == lvrc_pkg::ST_LVD_HOLD) && (state_nxt == lvrc_pkg::ST_RUN);

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= lvrc_pkg::ST_POR_HOLD;
            system_reset_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            system_reset_r <= (state_nxt != lvrc_pkg::ST_RUN);
        end
    end

    // Reset source: power-on loads both flags, a low-voltage reset leaves only its own.
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            srs_r <= lvrc_pkg::SRS_AFTER_POR;
        end
        else if (enter_lvd)
        begin
            srs_r <= lvrc_pkg::SRS_AFTER_LVD;
        end
    end

    // Control bits survive a low-voltage reset so the supervisor keeps guarding the recovery.
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= lvrc_pkg::CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            ctrl_r <= wdata_i[lvrc_pkg::CTRL_FIELD_W-1:0];
        end
    end

    // Stop mode requests are honoured only while the system runs; wake or any reset exits.
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_r <= lvrc_pkg::MODE_RUN;
        end
        else if (state_nxt != lvrc_pkg::ST_RUN)
        begin
            mode_r <= lvrc_pkg::MODE_RUN;
        end
        else if (mode_r == lvrc_pkg::MODE_RUN)
        begin
            if (stop_req_i)
            begin
                if (stop_deep_i && !(ctrl_r.sup_en && ctrl_r.stop_en))
                begin
                    mode_r <= lvrc_pkg::MODE_DEEP;
                end
                else
                begin
                    mode_r <= lvrc_pkg::MODE_RETAIN;
                end
            end
        end
        else if (wake_i)
        begin
            mode_r <= lvrc_pkg::MODE_RUN;
        end
    end

    // A new warning in the acknowledge cycle wins, so no warning is ever lost.
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            warn_flag_r <= 1'b0;
        end
        else if (warn_set)
        begin
            warn_flag_r <= 1'b1;
        end
        else if (warn_ack)
        begin
            warn_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            detect_prev_r <= 1'b0;
        end
        else
        begin
            detect_prev_r <= detect;
        end
    end

    // Detect is edge-triggered, so a supply that rests below cannot refill a cleared bit.
    always_comb
    begin
        irq_set = '0;
        irq_set[lvrc_pkg::IRQ_WARN_BIT] = warn_set && !warn_flag_r;
        irq_set[lvrc_pkg::IRQ_DETECT_BIT] = detect && !detect_prev_r && !ctrl_r.lvr_en;
        irq_set[lvrc_pkg::IRQ_RECOVER_BIT] = leave_lvd;
        irq_clr = '0;
        if (wr_i && (addr_i == lvrc_pkg::ADDR_IRQ_STAT))
        begin
            irq_clr = wdata_i[lvrc_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_stat_r <= '0;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_mask_r <= lvrc_pkg::IRQ_MASK_RESET;
        end
        else if (wr_i && (addr_i == lvrc_pkg::ADDR_IRQ_MASK))
        begin
            irq_mask_r <= wdata_i[lvrc_pkg::IRQ_W-1:0];
        end
    end

    // Read data stand for exactly the cycle after the strobe; writes to the reset source are ignored.
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r <= '0;
        end
        else if (rd_i)
        begin
            case (addr_i)
                lvrc_pkg::ADDR_CTRL:
                begin
                    rdata_r <= ctrl_view;
                end
                lvrc_pkg::ADDR_SRS:
                begin
                    rdata_r <= srs_r;
                end
                lvrc_pkg::ADDR_IRQ_STAT:
                begin
                    rdata_r <= {5'h00, irq_stat_r};
                end
                lvrc_pkg::ADDR_IRQ_MASK:
                begin
                    rdata_r <= {5'h00, irq_mask_r};
                end
                lvrc_pkg::ADDR_MODE:
                begin
                    rdata_r <= {5'h00, mode_r};
                end
                default:
                begin
                    rdata_r <= '0;
                end
            endcase
        end
        else
        begin
            rdata_r <= '0;
        end
    end

    assign rdata_o = rdata_r;
    assign system_reset_o = system_reset_r;
    assign stop_mode_o = mode_r;
    assign supervisor_active_o = active;
    assign warning_irq_o = warn_flag_r && ctrl_r.warn_ie;
    assign irq_o = |(irq_stat_r & irq_mask_r);

endmodule // lvrc_top

// File: tb/lvrc_supply_model.sv
// Supply comparator model: turns a supply level in millivolts into below-threshold levels.
module lvrc_supply_model #(
    parameter int LOW_MV = 2000,
    parameter int HIGH_MV = 2300,
    parameter int WARN_MV = 2600
) (
    input wire logic clk_i,
    input wire logic [15:0] supply_mv_i,
    output lvrc_pkg::lvrc_cmp_type cmp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Starts below every threshold, as a supply that is still ramping up would.
    initial cmp_o = 3'h7;
    // Registered, so a level change reaches the block only after a clock edge.
    always @(posedge clk_i)
    begin
        cmp_o.low_below <= int'(supply_mv_i) < LOW_MV;
        cmp_o.high_below <= int'(supply_mv_i) < HIGH_MV;
        cmp_o.warn_below <= int'(supply_mv_i) < WARN_MV;
    end
endmodule // lvrc_supply_model

// File: tb/lvrc_monitor.sv
// Port-level checker for the low-voltage reset control block.
module lvrc_monitor (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire lvrc_pkg::lvrc_cmp_type cmp_i,
    input wire logic stop_req_i,
    input wire logic stop_deep_i,
    input wire logic wake_i,
    input wire logic [lvrc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [lvrc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [lvrc_pkg::DATA_W-1:0] rdata_o,
    input wire logic system_reset_o,
    input wire lvrc_pkg::lvrc_mode_type stop_mode_o,
    input wire logic supervisor_active_o,
    input wire logic warning_irq_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] ctrl_r;
    logic run;
    logic sel_above;
    default clocking mcb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // Shadow of the control bits, so the enables can be named without reaching inside.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctrl_r <= lvrc_pkg::CTRL_RESET;
        end
        else if (wr_i && addr_i == lvrc_pkg::ADDR_CTRL)
        begin
            ctrl_r <= wdata_i[4:0];
        end
    end
    assign run = stop_mode_o == lvrc_pkg::MODE_RUN;
    assign sel_above = ctrl_r[3] ? !cmp_i.high_below : !cmp_i.low_below;
    chk_active_level: assert property (
        supervisor_active_o == (ctrl_r[0] && (run || ctrl_r[1])))
        else $error("supervisor activity wrong");
    chk_retain_stop: assert property (
        stop_req_i && stop_deep_i && ctrl_r[0] && ctrl_r[1] && run && !system_reset_o
        |=> stop_mode_o == lvrc_pkg::MODE_RETAIN)
        else $error("deep request not turned into retaining stop");
    chk_deep_stop: assert property (
        stop_req_i && stop_deep_i && !(ctrl_r[0] && ctrl_r[1]) && run && !system_reset_o
        |=> stop_mode_o == lvrc_pkg::MODE_DEEP)
        else $error("deepest stop not entered");
    chk_rdata_idle: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    chk_status_bits: assert property (
        $past(rd_i && addr_i == lvrc_pkg::ADDR_SRS) |-> rdata_o[6:0] == 7'h02)
        else $error("reset source layout wrong");
    chk_warn_enable: assert property (
        warning_irq_o |-> ctrl_r[4])
        else $error("warning request without enable");
    chk_hold_release: assert property (
        $fell(system_reset_o) |-> $past(sel_above, 2) && $past(sel_above, 5))
        else $error("reset released while supply below");
    chk_reset_cause: assert property (
        $rose(system_reset_o) |-> $past(ctrl_r[2]) && $past(supervisor_active_o))
        else $error("low-voltage reset while not enabled");
endmodule // lvrc_monitor
bind lvrc_top lvrc_monitor u_mon (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmp_i(cmp_i),
    .stop_req_i(stop_req_i), .stop_deep_i(stop_deep_i), .wake_i(wake_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .system_reset_o(system_reset_o), .stop_mode_o(stop_mode_o),
    .supervisor_active_o(supervisor_active_o), .warning_irq_o(warning_irq_o), .irq_o(irq_o));

// File: tb/test_low_voltage_reset_control.sv
// Self-checking bench for the low-voltage reset control block.
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module test_low_voltage_reset_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam lvrc_pkg::lvrc_mode_type M_RUN = lvrc_pkg::MODE_RUN;
    localparam lvrc_pkg::lvrc_mode_type M_RET = lvrc_pkg::MODE_RETAIN;
    localparam lvrc_pkg::lvrc_mode_type M_DEEP = lvrc_pkg::MODE_DEEP;
    typedef struct packed {
        logic [7:0] ctrl;
        logic stop;
        logic deep;
        lvrc_pkg::lvrc_mode_type mode;
        logic act;
        logic [15:0] mv;
        logic rst;
    } lvrc_row_type;
    lvrc_row_type rows [9];
    logic clk = 1'b0;
    logic reset_n;
    logic [15:0] supply_mv = 16'h05DC;
    logic stop_req = 1'b0;
    logic stop_deep = 1'b0;
    logic wake = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [7:0] d;
    logic sys_rst;
    lvrc_pkg::lvrc_mode_type mode;
    logic active;
    logic warn_irq;
    logic irq;
    lvrc_pkg::lvrc_cmp_type cmp;
    int fail_count = 0;
    int total_checks = 0;
    always #12.5 clk = ~clk;
    lvrc_supply_model u_supply (.clk_i(clk), .supply_mv_i(supply_mv), .cmp_o(cmp));
    lvrc_top uut (.clk_i(clk), .reset_n_i(reset_n), .cmp_i(cmp), .stop_req_i(stop_req),
        .stop_deep_i(stop_deep), .wake_i(wake), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .system_reset_o(sys_rst), .stop_mode_o(mode),
        .supervisor_active_o(active), .warning_irq_o(warn_irq), .irq_o(irq));
    task automatic print_verdict;
        if (fail_count == 0 && total_checks > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic pulse(input logic is_stop, input logic deep);
        @(posedge clk);
        stop_req <= is_stop;
        stop_deep <= deep;
        wake <= !is_stop;
        @(posedge clk);
        stop_req <= 1'b0;
        wake <= 1'b0;
        #1;
    endtask
    // Polls, because the power-on release time depends on the qualifier's start state.
    task automatic wait_rst(input logic v);
        for (int k = 0; k < 20 && sys_rst !== v; k++)
        begin
            @(posedge clk);
            #1;
        end
        `CHK(sys_rst, v)
    endtask
    task automatic settle(input logic [15:0] mv);
        supply_mv <= mv;
        repeat (12) @(posedge clk);
        #1;
    endtask
    initial
    begin
        #(25 * 5000);
        fail_count++;
        print_verdict;
    end
    initial
    begin
        reset_n <= 1'b0;
        rows = '{'{8'h05, 1'b0, 1'b0, M_RUN, 1'b1, 16'h0708, 1'b1},
            '{8'h01, 1'b0, 1'b0, M_RUN, 1'b1, 16'h0708, 1'b0},
            '{8'h04, 1'b0, 1'b0, M_RUN, 1'b0, 16'h0708, 1'b0},
            '{8'h0D, 1'b0, 1'b0, M_RUN, 1'b1, 16'h0834, 1'b1},
            '{8'h05, 1'b0, 1'b0, M_RUN, 1'b1, 16'h0834, 1'b0},
            '{8'h07, 1'b1, 1'b1, M_RET, 1'b1, 16'h0708, 1'b1},
            '{8'h05, 1'b1, 1'b1, M_DEEP, 1'b0, 16'h0708, 1'b0},
            '{8'h05, 1'b1, 1'b0, M_RET, 1'b0, 16'h0708, 1'b0},
            '{8'h0F, 1'b1, 1'b0, M_RET, 1'b1, 16'h0834, 1'b1}};
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        settle(16'h05DC);
        `CHK(sys_rst, 1'b1)
        supply_mv <= 16'h0CE4;
        wait_rst(1'b0);
        rd_reg(lvrc_pkg::ADDR_SRS);
        `CHK(d, lvrc_pkg::SRS_AFTER_POR)
        wr_reg(lvrc_pkg::ADDR_SRS, 8'h00);
        rd_reg(lvrc_pkg::ADDR_SRS);
        `CHK(d, lvrc_pkg::SRS_AFTER_POR)
        rd_reg(8'h7F);
        `CHK(d, 8'h00)
        foreach (rows[i])
        begin
            wr_reg(lvrc_pkg::ADDR_CTRL, rows[i].ctrl);
            if (rows[i].stop)
            begin
                pulse(1'b1, rows[i].deep);
            end
            `CHK(mode, rows[i].mode)
            `CHK(active, rows[i].act)
            rd_reg(lvrc_pkg::ADDR_MODE);
            `CHK(d, 8'(rows[i].mode))
            settle(rows[i].mv);
            `CHK(sys_rst, rows[i].rst)
            rd_reg(lvrc_pkg::ADDR_SRS);
            `CHK(d[1], 1'b1)
            settle(16'h0CE4);
            `CHK(sys_rst, 1'b0)
            pulse(1'b0, 1'b0);
            `CHK(mode, M_RUN)
        end
        `CHK(d, lvrc_pkg::SRS_AFTER_LVD)
        wr_reg(lvrc_pkg::ADDR_IRQ_MASK, 8'h03);
        `CHK(irq, 1'b1)
        wr_reg(lvrc_pkg::ADDR_IRQ_STAT, 8'h07);
        `CHK(irq, 1'b0)
        wr_reg(lvrc_pkg::ADDR_CTRL, 8'h15);
        settle(16'h0960);
        `CHK(warn_irq, 1'b1)
        `CHK(irq, 1'b1)
        rd_reg(lvrc_pkg::ADDR_CTRL);
        `CHK(d, 8'h35)
        wr_reg(lvrc_pkg::ADDR_IRQ_MASK, 8'h00);
        `CHK(irq, 1'b0)
        settle(16'h0CE4);
        `CHK(warn_irq, 1'b1)
        wr_reg(lvrc_pkg::ADDR_CTRL, 8'h55);
        `CHK(warn_irq, 1'b0)
        rd_reg(lvrc_pkg::ADDR_CTRL);
        `CHK(d, 8'h15)
        reset_n <= 1'b0;
        #1;
        `CHK(sys_rst, 1'b1)
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        wait_rst(1'b0);
        rd_reg(lvrc_pkg::ADDR_SRS);
        `CHK(d, lvrc_pkg::SRS_AFTER_POR)
        print_verdict;
    end
endmodule // test_low_voltage_reset_control
